//--- hdl/pio_consts.svh
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// *****************************************************
// Widths
// *****************************************************
`define PIO_WORD_W 12
`define PIO_SEL_W 6
`define PIO_TP_W 3

// *****************************************************
// Processor timing pulse positions
// *****************************************************
`define PIO_TP1_BIT 0
`define PIO_TP2_BIT 1
`define PIO_TP4_BIT 2

// *****************************************************
// Select codes of the two channels
// *****************************************************
`define PIO_IN_CODE 6'h1C
`define PIO_OUT_CODE 6'h1D

// *****************************************************
// Reset values
// *****************************************************
`define PIO_WORD_RST 12'h000
`define PIO_TP_RST 3'h0

`endif

//--- hdl/pio_pkg.sv
package pio_pkg;

  typedef logic [11:0] pio_word_t;

  typedef enum logic [1:0] {
    PIO_OUT_IDLE = 2'b00,
    PIO_OUT_BUSY = 2'b01,
    PIO_OUT_DONE = 2'b10
  } pio_out_state_e;

endpackage

//--- hdl/pio_sel_if.sv
`timescale 1ns/1ps
interface pio_sel_if;
  logic in_match;
  logic out_match;
  logic [2:0] in_lvl;
  logic [2:0] out_lvl;
  logic [2:0] in_edge;
  logic [2:0] out_edge;

  modport sel (
    output in_match,
    output out_match,
    output in_lvl,
    output out_lvl,
    output in_edge,
    output out_edge
  );

  modport dev (
    input in_match,
    input out_match,
    input in_lvl,
    input out_lvl,
    input in_edge,
    input out_edge
  );
endinterface

//--- hdl/pio_dev_sel.sv
`timescale 1ns/1ps
`include "pio_consts.svh"

module pio_dev_sel (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] tpulse_i,
  input wire logic [5:0] sel_i,
  pio_sel_if.sel cmd
);

  // *****************************************************
  // Select decode and command pulse regeneration
  // *****************************************************
  logic [2:0] tpulse_prev_q;

  function automatic logic [2:0] pio_gate(input logic m, input logic [2:0] v);
    pio_gate = m ? v : `PIO_TP_RST;
  endfunction

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tpulse_prev_q <= `PIO_TP_RST;
    end else begin
      tpulse_prev_q <= tpulse_i;
    end
  end

  assign cmd.in_match = (sel_i == `PIO_IN_CODE);
  assign cmd.out_match = (sel_i == `PIO_OUT_CODE);
  assign cmd.in_lvl = pio_gate(cmd.in_match, tpulse_i);
  assign cmd.out_lvl = pio_gate(cmd.out_match, tpulse_i);
  assign cmd.in_edge = pio_gate(cmd.in_match, tpulse_i & ~tpulse_prev_q);
  assign cmd.out_edge = pio_gate(cmd.out_match, tpulse_i & ~tpulse_prev_q);

endmodule // pio_dev_sel

//--- hdl/pio_dev_ctrl.sv
`timescale 1ns/1ps
`include "pio_consts.svh"

// How it works
// - Grounded input line sets work register bit
// - Clear-line-only command clears the work register
// - Ready input device raises skip-testable flag
// - Input word gated onto lines by pulse
// - Earlier pulse clears ready flag before input
// - Output captured on one pulse, started later
// - Output lines sampled only under select decode
// - Output register jam-loaded, never cleared first
// - One transfer carries at most twelve bits
// - Output strobe comes from processor command pulse
// - Status flag grounds shared interrupt request line
// - Interrupting flags also answer skip polling

module pio_dev_ctrl (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] tpulse_i,
  input wire logic [5:0] sel_i,
  input wire logic [11:0] bwr_i,
  output logic [11:0] wr_in_o,
  output logic [11:0] wr_in_oe_o,
  output logic clr_o,
  output logic clr_oe_o,
  output logic skip_o,
  output logic skip_oe_o,
  output logic irq_o,
  output logic irq_oe_o,
  input wire logic [11:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic clr_mode_i,
  input wire logic irq_en_i,
  output logic [11:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ack_i
);

  // *****************************************************
  // Command decode
  // *****************************************************
  pio_sel_if cmd ();

  pio_dev_sel u_sel (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tpulse_i(tpulse_i),
    .sel_i(sel_i),
    .cmd(cmd)
  );

  // *****************************************************
  // Input channel
  // *****************************************************
  pio_pkg::pio_word_t in_buf_q;
  logic in_flag_q;
  logic in_flag_d;
  logic in_ready_q;
  logic take;

  // No new word while the processor is addressing this channel
  assign take = in_valid_i && in_ready_q && !cmd.in_match;

  always_comb begin
    in_flag_d = in_flag_q;
    if (cmd.in_edge[`PIO_TP2_BIT]) begin
      in_flag_d = 1'b0;
    end
    if (take) begin
      in_flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_flag_q <= 1'b0;
    end else begin
      in_flag_q <= in_flag_d;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_buf_q <= `PIO_WORD_RST;
    end else if (take) begin
      in_buf_q <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_ready_q <= 1'b0;
    end else begin
      in_ready_q <= !in_flag_d && !take;
    end
  end

  // *****************************************************
  // Work register input lines, pulled low per one bit
  // *****************************************************
  logic [11:0] wr_in_oe_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_in_oe_q <= `PIO_WORD_RST;
    end else if (cmd.in_lvl[`PIO_TP4_BIT]) begin
      wr_in_oe_q <= in_buf_q;
    end else begin
      wr_in_oe_q <= `PIO_WORD_RST;
    end
  end

  // Clear line held only in the second pulse slot, never with data
  logic clr_oe_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clr_oe_q <= 1'b0;
    end else begin
      clr_oe_q <= cmd.in_lvl[`PIO_TP2_BIT] && clr_mode_i;
    end
  end

  // *****************************************************
  // Output channel
  // *****************************************************
  pio_pkg::pio_word_t out_q;
  pio_pkg::pio_out_state_e out_state_q;
  pio_pkg::pio_out_state_e out_state_d;
  logic out_valid_q;
  logic out_done;

  assign out_done = (out_state_q == pio_pkg::PIO_OUT_DONE);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_q <= `PIO_WORD_RST;
    end else if (cmd.out_edge[`PIO_TP2_BIT]) begin
      out_q <= bwr_i;
    end
  end

  always_comb begin
    out_state_d = out_state_q;
    case (out_state_q)
      pio_pkg::PIO_OUT_IDLE: begin
        if (cmd.out_edge[`PIO_TP4_BIT]) begin
          out_state_d = pio_pkg::PIO_OUT_BUSY;
        end
      end
      pio_pkg::PIO_OUT_BUSY: begin
        if (out_ack_i) begin
          out_state_d = pio_pkg::PIO_OUT_DONE;
        end
      end
      pio_pkg::PIO_OUT_DONE: begin
        if (cmd.out_edge[`PIO_TP4_BIT]) begin
          out_state_d = pio_pkg::PIO_OUT_BUSY;
        end else if (cmd.out_edge[`PIO_TP2_BIT]) begin
          out_state_d = pio_pkg::PIO_OUT_IDLE;
        end
      end
      default: begin
        out_state_d = pio_pkg::PIO_OUT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_state_q <= pio_pkg::PIO_OUT_IDLE;
      out_valid_q <= 1'b0;
    end else begin
      out_state_q <= out_state_d;
      out_valid_q <= (out_state_d == pio_pkg::PIO_OUT_BUSY);
    end
  end

  // *****************************************************
  // Skip and interrupt request
  // *****************************************************
  logic skip_oe_q;
  logic irq_oe_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      skip_oe_q <= 1'b0;
    end else begin
      skip_oe_q <= (cmd.in_lvl[`PIO_TP1_BIT] && in_flag_q) ||
                   (cmd.out_lvl[`PIO_TP1_BIT] && out_done);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_oe_q <= 1'b0;
    end else begin
      irq_oe_q <= irq_en_i && (in_flag_q || out_done);
    end
  end

  // Open-drain lines only ever drive low
  logic low_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_q <= 1'b0;
    end else begin
      low_q <= 1'b0;
    end
  end

  assign wr_in_o = {12{low_q}};
  assign wr_in_oe_o = wr_in_oe_q;
  assign clr_o = low_q;
  assign clr_oe_o = clr_oe_q;
  assign skip_o = low_q;
  assign skip_oe_o = skip_oe_q;
  assign irq_o = low_q;
  assign irq_oe_o = irq_oe_q;
  assign in_ready_o = in_ready_q;
  assign out_data_o = out_q;
  assign out_valid_o = out_valid_q;

  // *****************************************************
  // Assertions
  // *****************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_take_word;
    take ##1 in_flag_q;
  endsequence

  a_read_drives_word: assert property (
    cmd.in_lvl[`PIO_TP4_BIT] |=> wr_in_oe_o == $past(in_buf_q))
    else $error("input word not driven during read pulse");

  a_no_idle_drive: assert property (
    !cmd.in_lvl[`PIO_TP4_BIT] |=> wr_in_oe_o == `PIO_WORD_RST)
    else $error("input lines pulled outside read pulse");

  a_ready_after_take: assert property (
    take |-> s_take_word)
    else $error("ready flag not set after word taken");

  a_ready_refused: assert property (
    in_flag_q && !cmd.in_edge[`PIO_TP2_BIT] |=> !in_ready_o)
    else $error("new word accepted while ready flag set");

  a_flag_cleared: assert property (
    cmd.in_edge[`PIO_TP2_BIT] && !take |=> !in_flag_q ##1 (!irq_oe_q || $past(out_done)))
    else $error("ready flag survived clearing pulse");

  a_jam_capture: assert property (
    cmd.out_edge[`PIO_TP2_BIT] |=> out_data_o == $past(bwr_i))
    else $error("output word not captured on strobe");

  a_out_gated: assert property (
    !cmd.out_edge[`PIO_TP2_BIT] |=> $stable(out_data_o))
    else $error("output register changed without strobe");

  a_start_later: assert property (
    cmd.out_edge[`PIO_TP4_BIT] && !out_valid_o |=> out_valid_o ##1 out_valid_o || $past(out_ack_i))
    else $error("device not started by start pulse");

  a_start_needs_pulse: assert property (
    !out_valid_o && !cmd.out_edge[`PIO_TP4_BIT] |=> !out_valid_o)
    else $error("output started without command pulse");

  a_irq_quiet: assert property (
    !irq_en_i |=> !irq_oe_o)
    else $error("interrupt request while disabled");

  a_skip_quiet: assert property (
    !cmd.in_lvl[`PIO_TP1_BIT] && !cmd.out_lvl[`PIO_TP1_BIT] |=> !skip_oe_o)
    else $error("skip line pulled without poll pulse");

  a_clear_needs_mode: assert property (
    !clr_mode_i |=> !clr_oe_o)
    else $error("clear line pulled while clear mode off");

  a_irq_request: assert property (
    irq_en_i && in_flag_q |=> irq_oe_o)
    else $error("interrupt request missing for ready flag");

  a_skip_identify: assert property (
    cmd.in_lvl[`PIO_TP1_BIT] && in_flag_q |=> skip_oe_o)
    else $error("requesting flag did not answer skip poll");

  a_clear_alone: assert property (
    clr_oe_o |-> $past(cmd.in_lvl[`PIO_TP2_BIT]) && wr_in_oe_o == `PIO_WORD_RST)
    else $error("clear line asserted with data or off slot");

endmodule // pio_dev_ctrl

//--- testbench/pio_proc_model.sv
`timescale 1ns/1ps
// ****
// Processor side of the I/O bus
// ****
module pio_proc_model (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  output logic [2:0] tpulse_o,
  output logic [5:0] sel_o,
  output logic [11:0] bwr_o,
  input wire logic [11:0] wr_in_o,
  input wire logic [11:0] wr_in_oe_o,
  input wire logic clr_o,
  input wire logic clr_oe_o,
  input wire logic skip_o,
  input wire logic skip_oe_o,
  input wire logic irq_o,
  input wire logic irq_oe_o
);
  logic [11:0] wr_q;
  logic [11:0] pc_q;
  logic [11:0] ret_q;
  logic int_on_q;
  logic skip_q;
  logic irq_req;
  logic term_flag;
  initial begin
    tpulse_o = 3'h0;
    sel_o = 6'h00;
    pc_q = 12'h100;
    int_on_q = 1'b0;
  end
  // Built-in terminal flag stays idle here
  assign term_flag = 1'b0;
  assign irq_req = (irq_oe_o & ~irq_o) | term_flag;
  assign bwr_o = wr_q;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= 12'h000;
    end else begin
      wr_q <= ((clr_oe_o & ~clr_o) ? 12'h000 : wr_q) |
              (wr_in_oe_o & ~wr_in_o);
    end
  end
  task automatic issue_cmd(input logic [5:0] code, input logic [2:0] bits);
    logic sk;
    sk = 1'b0;
    @(posedge mclk_i);
    sel_o <= code;
    for (int b = 0; b < 3; b++) begin
      repeat (2) @(posedge mclk_i);
      tpulse_o <= bits & (3'h1 << b);
      repeat (3) @(posedge mclk_i);
      sk = sk | (skip_oe_o & ~skip_o);
      tpulse_o <= 3'h0;
    end
    repeat (3) @(posedge mclk_i);
    sel_o <= 6'h00;
    skip_q = sk;
    pc_q = pc_q + (sk ? 12'h002 : 12'h001);
    // Interrupt only at the instruction boundary
    if (int_on_q && irq_req) begin
      ret_q = pc_q;
      pc_q = 12'h001;
      int_on_q = 1'b0;
    end
  endtask
  task automatic interrupts_on_op;
    int_on_q = 1'b1;
  endtask
endmodule // pio_proc_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk_i;
  logic reset_n_i;
  logic [2:0] tpulse;
  logic [5:0] sel;
  logic [11:0] bwr;
  logic [11:0] wr_in;
  logic [11:0] wr_oe;
  logic clr, clr_oe, skip, skip_oe, irq, irq_oe;
  logic [11:0] in_data;
  logic [11:0] out_data;
  logic in_valid, in_ready, clr_mode, irq_en, out_valid, out_ack;
  int err_total;
  int cmp_count;
  pio_dev_ctrl pio_dev_ctrl_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .tpulse_i(tpulse),
    .sel_i(sel), .bwr_i(bwr), .wr_in_o(wr_in), .wr_in_oe_o(wr_oe), .clr_o(clr),
    .clr_oe_o(clr_oe), .skip_o(skip), .skip_oe_o(skip_oe), .irq_o(irq), .irq_oe_o(irq_oe),
    .in_data_i(in_data), .in_valid_i(in_valid), .in_ready_o(in_ready),
    .clr_mode_i(clr_mode), .irq_en_i(irq_en), .out_data_o(out_data),
    .out_valid_o(out_valid), .out_ack_i(out_ack));
  pio_proc_model pio_proc_model_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .tpulse_o(tpulse),
    .sel_o(sel), .bwr_o(bwr), .wr_in_o(wr_in), .wr_in_oe_o(wr_oe), .clr_o(clr),
    .clr_oe_o(clr_oe), .skip_o(skip), .skip_oe_o(skip_oe), .irq_o(irq), .irq_oe_o(irq_oe));
  // ****
  // Checking
  // ****
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("Mismatches %0d, compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send(input logic [11:0] w);
    int n;
    for (n = 0; n < 100 && in_ready !== 1'b1; n++) @(posedge mclk_i);
    check({11'h0, in_ready}, 12'h001);
    in_data <= w;
    in_valid <= 1'b1;
    @(posedge mclk_i);
    in_valid <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic s_input;
    irq_en <= 1'b1;
    send(12'hA05);
    check({11'h0, irq_oe & ~irq}, 12'h001);
    check({11'h0, in_ready}, 12'h000);
    pio_proc_model_i.issue_cmd(6'h1C, 3'h5);
    check({11'h0, pio_proc_model_i.skip_q}, 12'h001);
    check(pio_proc_model_i.wr_q, 12'hA05);
    pio_proc_model_i.issue_cmd(6'h1C, 3'h3);
    check({11'h0, irq_oe & ~irq}, 12'h000);
    pio_proc_model_i.issue_cmd(6'h1C, 3'h1);
    check({11'h0, pio_proc_model_i.skip_q}, 12'h000);
    send(12'h150);
    pio_proc_model_i.issue_cmd(6'h1C, 3'h6);
    check(pio_proc_model_i.wr_q, 12'hB55);
    clr_mode <= 1'b1;
    pio_proc_model_i.issue_cmd(6'h1C, 3'h2);
    check(pio_proc_model_i.wr_q, 12'h000);
    clr_mode <= 1'b0;
  endtask
  task automatic s_irq;
    irq_en <= 1'b0;
    send(12'h3C3);
    check({11'h0, irq_oe}, 12'h000);
    pio_proc_model_i.interrupts_on_op;
    irq_en <= 1'b1;
    repeat (4) @(posedge mclk_i);
    pio_proc_model_i.issue_cmd(6'h1C, 3'h4);
    check(pio_proc_model_i.wr_q, 12'h3C3);
    check(pio_proc_model_i.pc_q, 12'h001);
    check(pio_proc_model_i.ret_q, 12'h108);
    pio_proc_model_i.issue_cmd(6'h1C, 3'h2);
  endtask
  task automatic s_output;
    pio_proc_model_i.issue_cmd(6'h1D, 3'h6);
    check(out_data, 12'h3C3);
    check({11'h0, out_valid}, 12'h001);
    clr_mode <= 1'b1;
    pio_proc_model_i.issue_cmd(6'h1C, 3'h2);
    clr_mode <= 1'b0;
    send(12'h03C);
    pio_proc_model_i.issue_cmd(6'h1E, 3'h7);
    check(out_data, 12'h3C3);
    out_ack <= 1'b1;
    @(posedge mclk_i);
    out_ack <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check({11'h0, out_valid}, 12'h000);
    check({11'h0, irq_oe & ~irq}, 12'h001);
    pio_proc_model_i.issue_cmd(6'h1D, 3'h1);
    check({11'h0, pio_proc_model_i.skip_q}, 12'h001);
    pio_proc_model_i.issue_cmd(6'h1C, 3'h4);
    pio_proc_model_i.issue_cmd(6'h1D, 3'h2);
    check(out_data, 12'h03C);
    pio_proc_model_i.issue_cmd(6'h1D, 3'h1);
    check({11'h0, pio_proc_model_i.skip_q}, 12'h000);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    finish_test;
  end
  initial begin
    err_total = 0;
    cmp_count = 0;
    reset_n_i = 1'b0;
    in_data = 12'h000;
    in_valid = 1'b0;
    clr_mode = 1'b0;
    irq_en = 1'b0;
    out_ack = 1'b0;
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    s_input;
    s_irq;
    s_output;
    finish_test;
  end
endmodule // tb
